// file: speed_measure_timer.sv
// speed measurement timer: 16-bit capture counter with auto prescaler
// What this block does
// - chained 16-bit counter, capture then clear
// - encoder counts upward, direction bit ignored
// - high capture read locks low unless a capture lands that cycle, drops captures
// - speed error at limit:ff match
// - sensor edge starts capture
// - encoder capture by counter read or rtc
// - counter source: system clock or encoder
// - at ffff prescaler up, shift right
// - capture below 5500 prescaler down, no shift
// - prescaler zero never decrements or flags
// - prescaler 15 at ffff saturates counter
// - hardware updates counter, capture, prescaler
// - capture raises capture interrupt
// - speed error shares emergency stop line
// - separate masks for capture, ratio, speed error; emergency stop unmasked
// - low counter byte readable in every mode
// - registers read zero after reset
// - capture debug signal on pin
// - speed mode: counter, prescaler read only
// - clock disabled: everything writable
//
// Local design decisions: the address-and-strobe port and the address map.
module speed_measure_timer
    import speed_measure_timer_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    input  wire logic              sensor_edge_i,
    input  wire logic              encoder_pulse_i,
    input  wire logic              rtc_tick_i,
    input  wire logic              emergency_stop_i,
    output logic                   capture_irq_o,
    output logic                   ratio_irq_o,
    output logic                   stop_irq_o,
    output logic                   capture_debug_o
);

    state_t      s;
    state_t      next_s;
    reg_req_t    req;
    logic        running;
    logic        encoder;
    logic        source_tick;
    logic        tick;
    logic        capture_request;
    logic        capture_take;
    logic        match;
    logic [14:0] div_mask;

    assign req.addr  = reg_addr_i;
    assign req.wdata = reg_wdata_i;
    assign req.wr    = reg_wr_i;
    assign req.rd    = reg_rd_i;

    assign running = s.clock_enable && (s.sensor != SENSOR_OFF);
    assign encoder = (s.sensor == SENSOR_ENCODER);

    assign source_tick = encoder ? encoder_pulse_i : 1'b1;

    // divide by two to the prescaler
    assign div_mask = 15'((DIV_ONE << s.prescaler) - DIV_ONE);
    // compare, not mask: a lowered prescaler must not skip a tick
    assign tick     = running && source_tick && (s.divider >= div_mask);

    always_comb begin
        capture_request = 1'b0;
        if (running) begin
            if (!encoder) begin
                capture_request = sensor_edge_i;
            end else if (s.encoder_capture_mode) begin
                capture_request = req.rd && (req.addr == ADDR_COUNTER_HIGH);
            end else begin
                capture_request = rtc_tick_i;
            end
        end
    end

    // locked low byte drops the capture
    assign capture_take = capture_request && !s.low_locked;

    // limit compare against low byte ff
    assign match = (s.counter[15:8] == s.speed_limit) && (s.counter[7:0] == LOW_BYTE_FULL);

    always_comb begin
        next_s       = s;
        next_s.rdata = '0;

        // register writes
        if (req.wr) begin
            if (req.addr == ADDR_COUNTER_HIGH) begin
                // counter writable only with clock off
                if (!s.clock_enable) begin
                    next_s.counter[15:8] = req.wdata;
                end
            end else if (req.addr == ADDR_COUNTER_LOW) begin
                if (!s.clock_enable) begin
                    next_s.counter[7:0] = req.wdata;
                end
            end else if (req.addr == ADDR_CAPTURE_HIGH) begin
                next_s.capture[15:8] = req.wdata;
            end else if (req.addr == ADDR_CAPTURE_LOW) begin
                next_s.capture[7:0] = req.wdata;
            end else if (req.addr == ADDR_COMMUTATION) begin
                next_s.commutation = req.wdata;
            end else if (req.addr == ADDR_SPEED_LIMIT) begin
                next_s.speed_limit = req.wdata;
            end else if (req.addr == ADDR_PRESCALER) begin
                if (!running) begin
                    next_s.prescaler = req.wdata[3:0];
                end
            end else if (req.addr == ADDR_CONTROL) begin
                next_s.clock_enable           = req.wdata[CTRL_CLOCK_ENABLE];
                next_s.sensor                 = sensor_t'(req.wdata[CTRL_SENSOR_MSB:CTRL_SENSOR_LSB]);
                next_s.encoder_capture_mode   = req.wdata[CTRL_ENC_CAPTURE];
                next_s.count_direction_select = req.wdata[CTRL_DIRECTION];
            end else if (req.addr == ADDR_STATUS) begin
                // write one to clear; hardware sets below still win
                next_s.flags = s.flags & ~req.wdata[FLAG_W-1:0];
            end else if (req.addr == ADDR_MASK) begin
                next_s.mask = req.wdata[MASK_W-1:0];
            end
        end

        // register reads, data stands in the next cycle only
        if (req.rd) begin
            if (req.addr == ADDR_COUNTER_HIGH) begin
                next_s.rdata = s.counter[15:8];
            end else if (req.addr == ADDR_COUNTER_LOW) begin
                // low byte reads the counter in every mode
                next_s.rdata = s.counter[7:0];
            end else if (req.addr == ADDR_CAPTURE_HIGH) begin
                next_s.rdata = s.capture[15:8];
                // high read locks the low byte unless a capture lands in the same cycle
                next_s.low_locked = 1'b1;
            end else if (req.addr == ADDR_CAPTURE_LOW) begin
                next_s.rdata      = s.capture[7:0];
                next_s.low_locked = 1'b0;
            end else if (req.addr == ADDR_COMMUTATION) begin
                next_s.rdata = s.commutation;
            end else if (req.addr == ADDR_SPEED_LIMIT) begin
                next_s.rdata = s.speed_limit;
            end else if (req.addr == ADDR_PRESCALER) begin
                next_s.rdata = {4'h0, s.prescaler};
            end else if (req.addr == ADDR_CONTROL) begin
                next_s.rdata = {3'h0, s.count_direction_select, s.encoder_capture_mode, s.sensor, s.clock_enable};
            end else if (req.addr == ADDR_STATUS) begin
                next_s.rdata = {3'h0, s.flags};
            end else if (req.addr == ADDR_MASK) begin
                next_s.rdata = {5'h0, s.mask};
            end else begin
                next_s.rdata = '0;
            end
        end

        // divider restarts on each tick so a prescaler change takes effect cleanly
        if (!running) begin
            next_s.divider = '0;
        end else if (tick) begin
            next_s.divider = '0;
        end else if (source_tick) begin
            next_s.divider = 15'(s.divider + DIV_ONE);
        end

        // hardware moves the counter, capture and prescaler
        if (running) begin
            if (capture_take) begin
                next_s.capture                = s.counter;
                next_s.counter                = '0;
                next_s.low_locked             = 1'b0;
                next_s.flags[FLAG_CAPTURE]    = 1'b1;
                // speed up on short period, floor at zero
                if ((s.counter < COUNTER_DOWN_LIM) && (s.prescaler != PRESC_MIN)) begin
                    next_s.prescaler              = s.prescaler - 4'h1;
                    next_s.flags[FLAG_PRESC_DOWN] = 1'b1;
                end
            end else if (tick) begin
                if (s.counter == COUNTER_MAX) begin
                    if (s.prescaler != PRESC_MAX) begin
                        next_s.prescaler            = s.prescaler + 4'h1;
                        next_s.counter              = COUNTER_HALF;
                        next_s.flags[FLAG_PRESC_UP] = 1'b1;
                    end
                end else begin
                    // always up; direction bit has no effect here
                    next_s.counter = s.counter + 16'h0001;
                end
            end
        end

        // flag on the first cycle of a match
        next_s.match_q = match;
        if (running && match && !s.match_q) begin
            next_s.flags[FLAG_SPEED_ERROR] = 1'b1;
        end
        if (emergency_stop_i) begin
            next_s.flags[FLAG_EMERGENCY] = 1'b1;
        end

        next_s.capture_debug = capture_take;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o     = s.rdata;
    assign capture_debug_o = s.capture_debug;

    assign capture_irq_o = s.flags[FLAG_CAPTURE] && s.mask[MASK_CAPTURE];
    assign ratio_irq_o   = (s.flags[FLAG_PRESC_UP] || s.flags[FLAG_PRESC_DOWN]) && s.mask[MASK_RATIO];
    // emergency stop and speed error share one line, separate flags
    assign stop_irq_o    = s.flags[FLAG_EMERGENCY] || (s.flags[FLAG_SPEED_ERROR] && s.mask[MASK_SPEED_ERROR]);

    // checks
    AST_CAPTURE_CLEARS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        capture_take |=> (s.counter == 16'h0000) && (s.capture == $past(s.counter)))
        else $error("capture did not store and clear the counter");

    AST_ENCODER_DIRECTION: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (running && encoder && tick && !capture_take && (s.counter != COUNTER_MAX))
        |=> (s.counter == $past(s.counter) + 16'h0001))
        else $error("encoder count did not advance upward");

    AST_LOCK_DROPS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (s.low_locked && capture_request && !req.wr) |=> $stable(s.capture))
        else $error("capture overwritten while low byte locked");

    AST_SPEED_ERROR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (running && match && !s.match_q)
        |=> s.flags[FLAG_SPEED_ERROR] && (stop_irq_o == (s.flags[FLAG_EMERGENCY] || s.mask[MASK_SPEED_ERROR])))
        else $error("speed error flag not raised on match");

    AST_ENCODER_READ_CAPTURE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (running && encoder && s.encoder_capture_mode && !s.low_locked && req.rd && (req.addr == ADDR_COUNTER_HIGH))
        |=> s.flags[FLAG_CAPTURE] && capture_debug_o && (s.counter == 16'h0000))
        else $error("counter high read did not capture");

    AST_PRESC_UP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (tick && !capture_take && (s.counter == COUNTER_MAX) && (s.prescaler != PRESC_MAX))
        |=> (s.counter == COUNTER_HALF) && (s.prescaler == $past(s.prescaler) + 4'h1) && s.flags[FLAG_PRESC_UP])
        else $error("overflow did not raise prescaler");

    AST_PRESC_DOWN: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (capture_take && (s.counter < COUNTER_DOWN_LIM) && (s.prescaler != PRESC_MIN))
        |=> (s.prescaler == $past(s.prescaler) - 4'h1) && s.flags[FLAG_PRESC_DOWN])
        else $error("short period did not lower prescaler");

    AST_PRESC_FLOOR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (capture_take && (s.prescaler == PRESC_MIN) && !s.flags[FLAG_PRESC_DOWN] && !req.wr)
        |=> (s.prescaler == PRESC_MIN) && !s.flags[FLAG_PRESC_DOWN])
        else $error("prescaler went below zero or flagged");

    AST_SATURATE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (running && (s.counter == COUNTER_MAX) && (s.prescaler == PRESC_MAX) && !capture_take && !req.wr)
        |=> (s.counter == COUNTER_MAX) && (s.prescaler == PRESC_MAX))
        else $error("saturated counter moved");

    AST_READ_ONLY: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (running && req.wr && (req.addr == ADDR_PRESCALER) && !tick && !capture_take)
        |=> $stable(s.prescaler))
        else $error("prescaler written in speed mode");

    COV_CAPTURE: cover property (@(posedge mclk_i) disable iff (!reset_n_i) capture_take ##1 capture_irq_o);
    COV_PRESC_UP: cover property (@(posedge mclk_i) disable iff (!reset_n_i) $rose(s.flags[FLAG_PRESC_UP]));
    COV_LOCKED_DROP: cover property (@(posedge mclk_i) disable iff (!reset_n_i) s.low_locked && capture_request);
    COV_SPEED_ERROR: cover property (@(posedge mclk_i) disable iff (!reset_n_i) $rose(s.flags[FLAG_SPEED_ERROR]));

endmodule

// file: speed_measure_timer_pkg.sv
// shared constants and types of the speed measurement timer
package speed_measure_timer_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_COUNTER_HIGH  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER_LOW   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_HIGH  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_LOW   = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_COMMUTATION   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_SPEED_LIMIT   = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALER     = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL       = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_STATUS        = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_MASK          = 4'h9;

    // control register fields
    localparam int unsigned CTRL_CLOCK_ENABLE = 0;
    localparam int unsigned CTRL_SENSOR_LSB   = 1;
    localparam int unsigned CTRL_SENSOR_MSB   = 2;
    localparam int unsigned CTRL_ENC_CAPTURE  = 3;
    localparam int unsigned CTRL_DIRECTION    = 4;

    // status flag positions
    localparam int unsigned FLAG_CAPTURE     = 0;
    localparam int unsigned FLAG_PRESC_UP    = 1;
    localparam int unsigned FLAG_PRESC_DOWN  = 2;
    localparam int unsigned FLAG_SPEED_ERROR = 3;
    localparam int unsigned FLAG_EMERGENCY   = 4;
    localparam int unsigned FLAG_W           = 5;

    // mask positions
    localparam int unsigned MASK_CAPTURE     = 0;
    localparam int unsigned MASK_RATIO       = 1;
    localparam int unsigned MASK_SPEED_ERROR = 2;
    localparam int unsigned MASK_W           = 3;

    localparam logic [15:0] COUNTER_MAX      = 16'hffff;
    localparam logic [15:0] COUNTER_HALF     = 16'h7fff;
    localparam logic [15:0] COUNTER_DOWN_LIM = 16'h5500;
    localparam logic [7:0]  LOW_BYTE_FULL    = 8'hff;
    localparam logic [3:0]  PRESC_MAX        = 4'hf;
    localparam logic [3:0]  PRESC_MIN        = 4'h0;
    localparam logic [14:0] DIV_ONE          = 15'h0001;

    typedef enum logic [1:0] {
        SENSOR_OFF     = 2'b00,
        SENSOR_TACHO   = 2'b01,
        SENSOR_HALL    = 2'b11,
        SENSOR_ENCODER = 2'b10
    } sensor_t;

    typedef struct packed {
        logic [15:0]       counter;
        logic [15:0]       capture;
        logic [3:0]        prescaler;
        logic [14:0]       divider;
        logic [7:0]        commutation;
        logic [7:0]        speed_limit;
        logic              clock_enable;
        sensor_t           sensor;
        logic              encoder_capture_mode;
        logic              count_direction_select;
        logic [FLAG_W-1:0] flags;
        logic [MASK_W-1:0] mask;
        logic              low_locked;
        logic              match_q;
        logic              capture_debug;
        logic [7:0]        rdata;
    } state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage

// file: sensor_source.sv
// pulse source standing in for tacho, hall sensors, encoder and rtc
module sensor_source (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [15:0] edge_period_i,
    input  wire logic [7:0]  encoder_period_i,
    input  wire logic [15:0] rtc_period_i,
    output logic             sensor_edge_o,
    output logic             encoder_pulse_o,
    output logic             rtc_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int edge_cnt;
    int enc_cnt;
    int rtc_cnt;
    initial begin
        sensor_edge_o = 1'b0;
        encoder_pulse_o = 1'b0;
        rtc_tick_o = 1'b0;
    end
    // a period of zero parks that source; short periods give fast sensors
    always @(posedge mclk_i) begin
        edge_cnt <= (!reset_n_i || edge_cnt + 1 >= edge_period_i) ? 0 : edge_cnt + 1;
        enc_cnt <= (!reset_n_i || enc_cnt + 1 >= encoder_period_i) ? 0 : enc_cnt + 1;
        rtc_cnt <= (!reset_n_i || rtc_cnt + 1 >= rtc_period_i) ? 0 : rtc_cnt + 1;
        sensor_edge_o <= reset_n_i && edge_period_i != 0 && edge_cnt + 1 >= edge_period_i;
        encoder_pulse_o <= reset_n_i && encoder_period_i != 0 && enc_cnt + 1 >= encoder_period_i;
        rtc_tick_o <= reset_n_i && rtc_period_i != 0 && rtc_cnt + 1 >= rtc_period_i;
    end
endmodule

// file: speed_measure_timer_test.sv
// self-checking bench of the speed measurement timer against a cycle model
module speed_measure_timer_test
    import speed_measure_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int cnt, cap, p, dv, lim, cmp, ctl, fl, mk, lock, mq, rd;} model_t;
    logic        mclk;
    logic        reset_n;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        sedge;
    logic        encp;
    logic        rtc;
    logic        estop;
    logic        cirq;
    logic        rirq;
    logic        sirq;
    logic        dbgo;
    logic [15:0] eperiod;
    logic [7:0]  nperiod;
    logic [15:0] tperiod;
    model_t      mdl;
    bit          run;
    bit          enc;
    bit          trig;
    bit          match;
    bit          tick;
    bit          dbg;
    int          hs;
    int          seed;
    int          cycles;
    int          n_mismatch;
    int          check_count;
    logic [7:0]  rnd;

    speed_measure_timer i_speed_measure_timer (.mclk_i(mclk), .reset_n_i(reset_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sensor_edge_i(sedge),
        .encoder_pulse_i(encp), .rtc_tick_i(rtc), .emergency_stop_i(estop), .capture_irq_o(cirq),
        .ratio_irq_o(rirq), .stop_irq_o(sirq), .capture_debug_o(dbgo));
    sensor_source i_sensor_source (.mclk_i(mclk), .reset_n_i(reset_n), .edge_period_i(eperiod),
        .encoder_period_i(nperiod), .rtc_period_i(tperiod), .sensor_edge_o(sedge),
        .encoder_pulse_o(encp), .rtc_tick_o(rtc));

    always #5 mclk = ~mclk;

    task automatic end_of_test();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rdr(input logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask

    // reference model: one step per edge, from the inputs seen before the edge
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
        if (!reset_n) begin
            mdl = '{default: 0};
            dbg = 0;
        end else begin
            run = mdl.ctl[0] && mdl.ctl[2:1] != 0;
            enc = mdl.ctl[2:1] == 2;
            hs = estop ? 16 : 0;
            mdl.rd = 0;
            if (rd) case (addr)
                0: mdl.rd = mdl.cnt >> 8;
                1: mdl.rd = mdl.cnt & 255;
                2: mdl.rd = mdl.cap >> 8;
                3: mdl.rd = mdl.cap & 255;
                4: mdl.rd = mdl.cmp;
                5: mdl.rd = mdl.lim;
                6: mdl.rd = mdl.p;
                7: mdl.rd = mdl.ctl;
                8: mdl.rd = mdl.fl;
                9: mdl.rd = mdl.mk;
                default: mdl.rd = 0;
            endcase
            trig = run && (enc ? (mdl.ctl[3] ? rd && addr == 0 : rtc) : sedge);
            dbg = trig && !mdl.lock;
            match = mdl.cnt == (mdl.lim << 8 | 255);
            if (run && match && !mdl.mq) hs |= 8;
            mdl.mq = match;
            tick = 0;
            if (run && (!enc || encp)) begin
                mdl.dv++;
                tick = mdl.dv >= 1 << mdl.p;
                if (tick) mdl.dv = 0;
            end
            if (!run) mdl.dv = 0;
            if (dbg) begin
                if (mdl.cnt < 'h5500 && mdl.p != 0) begin
                    mdl.p--;
                    hs |= 4;
                end
                mdl.cap = mdl.cnt;
                mdl.cnt = 0;
                mdl.lock = 0;
                hs |= 1;
            end else if (tick && mdl.cnt != 'hffff) mdl.cnt++;
            else if (tick && mdl.p < 15) begin
                mdl.p++;
                mdl.cnt = 'h7fff;
                hs |= 2;
            end
            if (rd && addr == 2) mdl.lock = 1;
            if (rd && addr == 3) mdl.lock = 0;
            if (wr) case (addr)
                0: if (!mdl.ctl[0]) mdl.cnt = wdata << 8 | mdl.cnt & 255;
                1: if (!mdl.ctl[0]) mdl.cnt = mdl.cnt & 'hff00 | wdata;
                2: mdl.cap = wdata << 8 | mdl.cap & 255;
                3: mdl.cap = mdl.cap & 'hff00 | wdata;
                4: mdl.cmp = wdata;
                5: mdl.lim = wdata;
                6: if (!run) mdl.p = wdata & 15;
                7: mdl.ctl = wdata & 31;
                8: mdl.fl = mdl.fl & ~wdata;
                9: mdl.mk = wdata & 7;
                default: ;
            endcase
            mdl.fl = mdl.fl | hs;
        end
    end

    // outputs settle by the falling edge
    always @(negedge mclk) if (reset_n) begin
        chk(rdata, mdl.rd[7:0], "read data");
        chk({4'h0, cirq, rirq, sirq, dbgo}, {4'h0, mdl.fl[0] & mdl.mk[0], (mdl.fl[1] | mdl.fl[2]) & mdl.mk[1],
            mdl.fl[4] | mdl.fl[3] & mdl.mk[2], dbg}, "irq lines");
    end

    initial begin
        mclk = 0; reset_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0; estop = 0;
        eperiod = 0; nperiod = 0; tperiod = 0; seed = 32'hf832;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        for (int a = 0; a < 16; a++) rdr(a[3:0]);
        // configure first, then prove the running block refuses counter writes
        wrr(ADDR_PRESCALER, 8'h02);
        wrr(ADDR_MASK, 8'h07);
        wrr(ADDR_CONTROL, 8'h03);
        wrr(ADDR_COUNTER_HIGH, 8'h12);
        wrr(ADDR_PRESCALER, 8'h05);
        eperiod <= 16'd40 + 16'($random(seed) & 63);
        repeat (400) @(posedge mclk);
        rdr(ADDR_CAPTURE_HIGH);
        repeat (120) @(posedge mclk);
        rdr(ADDR_CAPTURE_LOW);
        rdr(ADDR_STATUS);
        wrr(ADDR_STATUS, 8'h1f);
        eperiod <= 16'h0;
        // overflow raises the prescaler, then the limit match fires
        wrr(ADDR_CONTROL, 8'h00);
        wrr(ADDR_COUNTER_HIGH, 8'hff);
        wrr(ADDR_COUNTER_LOW, 8'hf0);
        wrr(ADDR_PRESCALER, 8'h00);
        wrr(ADDR_SPEED_LIMIT, 8'h7f);
        wrr(ADDR_CONTROL, 8'h07);
        repeat (40) @(posedge mclk);
        rdr(ADDR_COUNTER_HIGH);
        rdr(ADDR_COUNTER_LOW);
        // saturated counter at the slowest prescaler still captures
        wrr(ADDR_CONTROL, 8'h00);
        wrr(ADDR_COUNTER_HIGH, 8'hff);
        wrr(ADDR_COUNTER_LOW, 8'hff);
        wrr(ADDR_PRESCALER, 8'h0f);
        wrr(ADDR_CONTROL, 8'h03);
        repeat (30) @(posedge mclk);
        eperiod <= 16'd9;
        repeat (30) @(posedge mclk);
        eperiod <= 16'h0;
        rdr(ADDR_CAPTURE_HIGH);
        rdr(ADDR_CAPTURE_LOW);
        // encoder counts up with the direction bit set
        wrr(ADDR_CONTROL, 8'h00);
        wrr(ADDR_PRESCALER, 8'h00);
        wrr(ADDR_COUNTER_HIGH, 8'h00);
        wrr(ADDR_COUNTER_LOW, 8'h00);
        nperiod <= 8'd3;
        wrr(ADDR_CONTROL, 8'h1d);
        repeat (60) @(posedge mclk);
        rdr(ADDR_COUNTER_HIGH);
        rdr(ADDR_CAPTURE_LOW);
        rdr(ADDR_COUNTER_HIGH);
        wrr(ADDR_CONTROL, 8'h15);
        tperiod <= 16'd50;
        repeat (200) @(posedge mclk);
        tperiod <= 16'h0;
        // emergency stop shares the stop line with speed errors
        @(posedge mclk);
        estop <= 1'b1;
        @(posedge mclk);
        estop <= 1'b0;
        wrr(ADDR_STATUS, 8'h08);
        wrr(ADDR_STATUS, 8'h1f);
        wrr(ADDR_COMMUTATION, 8'($random(seed)));
        rdr(ADDR_COMMUTATION);
        // random register traffic; unmapped addresses read zero
        repeat (60) begin
            rnd = 8'($random(seed));
            if (rnd[4]) wrr(rnd[3:0], 8'($random(seed)));
            else rdr(rnd[3:0]);
        end
        repeat (5) @(posedge mclk);
        end_of_test();
    end
endmodule
